// ---- pss_sram_port.sv ----
`timescale 1ns/1ps
`include "pss_map.svh"

module pss_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // flags straight from the count, so full and empty stay honest
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];

  // pointers and count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage carries no reset
  always_ff @(posedge clk_sys) begin
    if (push) mem_r[wp_r] <= in_data;
  end
endmodule : pss_fifo

// Notes on behaviour
// - every synchronous input is captured in a register on the clock edge
// - address and selects latch only on an edge with either address strobe
// - a two-bit burst counter supplies the low address bits
// - later burst addresses come from the counter, stepping on advance only
// - burst order is interleaved or linear, chosen by the user
// - writes register address, data and controls, then finish self-timed
// - per-lane enables qualified by the byte gate pick lanes to write
// - global write low writes every lane regardless of lane enables
// - output enable and sleep act without the clock
// - read data is registered; four-beat burst runs four-one-one-one
// - deselect takes effect within one clock of being sampled
// - three chip selects, strobes, advance and write enables are registered
// - array is 2M by 36 with four lanes or 4M by 18 with two
module pss_sram_port #(
  parameter bit WIDE   = 1'b1,
  parameter int DATA_W = WIDE ? `PSS_WIDE_DATA_W : `PSS_NARROW_DATA_W,
  parameter int ADDR_W = WIDE ? `PSS_WIDE_ADDR_W : `PSS_NARROW_ADDR_W,
  parameter int LANES  = DATA_W / `PSS_LANE_W,
  parameter int DEPTH  = `PSS_FIFO_DEPTH
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe,
  input  wire logic              pipeline_chip_sel_n,
  input  wire logic              depth_sel_high,
  input  wire logic              depth_sel_low_n,
  input  wire logic              cpu_addr_strobe_n,
  input  wire logic              ctrl_addr_strobe_n,
  input  wire logic              burst_step_request_n,
  input  wire logic [LANES-1:0]  byte_lane_write_n,
  input  wire logic              byte_write_gate_n,
  input  wire logic              all_lanes_write_n,
  input  wire logic              out_enable_n,
  input  wire logic              sleep_request,
  input  wire logic              linear_order,
  output logic                   asleep,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [DATA_W-1:0]      mem_wdata,
  output logic [LANES-1:0]       mem_lane_we,
  output logic                   mem_req_valid,
  input  wire logic              mem_req_ready,
  input  wire logic [DATA_W-1:0] mem_rdata
);
  localparam int BW = `PSS_BURST_W;

  // registered copies of the pins, named for what each pin does
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] din_r;
  logic              pcs_n_r;   // pipelining select
  logic              dsh_r;     // depth select, active high
  logic              dsl_n_r;   // depth select, active low
  logic              cstb_n_r;  // processor address strobe
  logic              kstb_n_r;  // controller address strobe
  logic              step_n_r;  // burst step request
  logic [LANES-1:0]  lane_n_r;
  logic              gate_n_r;
  logic              glob_n_r;
  logic              lin_r;
  // burst state
  logic [ADDR_W-1:0] base_r;
  logic [BW-1:0]     cnt_r;
  logic              sel_r;
  logic              ord_r;
  pss_pkg::pss_state_e state_r;
  // write beat kept with its address; later pin edges other than a strobe cannot disturb it
  logic [LANES-1:0]  wlanes_r;
  logic [DATA_W-1:0] wdata_r;
  // read pipeline
  logic [DATA_W-1:0] dout_r;
  logic              dout_v_r;
  logic              rd_pend_r;

  // interleaved order xors the counter into the start bits; linear adds
  function automatic logic [BW-1:0] beat_lo(input logic [BW-1:0] start,
                                            input logic [BW-1:0] cnt,
                                            input logic          lin);
    beat_lo = lin ? BW'(start + cnt) : (start ^ cnt);
  endfunction : beat_lo

  // decode of the registered controls
  wire strobe   = !cstb_n_r || !kstb_n_r;
  wire chip_on  = !pcs_n_r && dsh_r && !dsl_n_r;
  wire advance  = !strobe && !step_n_r && sel_r;
  wire all_wr   = !glob_n_r;
  wire [LANES-1:0] lane_we = all_wr ? {LANES{1'b1}}
                           : (gate_n_r ? '0 : ~lane_n_r);
  // a processor strobe always reads first; a write needs a later edge
  wire is_write = (lane_we != '0) && cstb_n_r;
  wire [ADDR_W-1:0] cur_addr = {base_r[ADDR_W-1:BW],
                                beat_lo(base_r[BW-1:0], cnt_r, ord_r)};
  wire busy     = (state_r != pss_pkg::PSS_IDLE);
  wire mem_go   = busy && !asleep;
  wire accept   = mem_go && mem_req_ready;
  // a beat that the array has not taken yet must stay exactly as it is unless a strobe replaces it
  wire stalled  = busy && !accept;
  wire load_wr  = (strobe && chip_on && is_write)
                  || (advance && !stalled && (lane_we != '0));

  // pin capture on every edge
  always_ff @(posedge clk_sys) begin
    addr_r   <= addr;
    din_r    <= dq_in;
    pcs_n_r  <= pipeline_chip_sel_n;
    dsh_r    <= depth_sel_high;
    dsl_n_r  <= depth_sel_low_n;
    cstb_n_r <= cpu_addr_strobe_n;
    kstb_n_r <= ctrl_addr_strobe_n;
    step_n_r <= burst_step_request_n;
    lane_n_r <= byte_lane_write_n;
    gate_n_r <= byte_write_gate_n;
    glob_n_r <= all_lanes_write_n;
    lin_r    <= linear_order;
  end

  // address latch and burst counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      base_r <= '0;
      cnt_r  <= '0;
      sel_r  <= 1'b0;
      ord_r  <= 1'b0;
    end else if (strobe) begin
      base_r <= addr_r;
      sel_r  <= chip_on;
      cnt_r  <= '0;
      ord_r  <= lin_r;
    end else if (advance && !stalled) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // one array beat per selecting strobe or advance; a stall holds the beat unless a new strobe arrives
  always_ff @(posedge clk_sys) begin
    if (rst) state_r <= pss_pkg::PSS_IDLE;
    else if (strobe && chip_on)
      state_r <= is_write ? pss_pkg::PSS_WRITE : pss_pkg::PSS_READ;
    else if (strobe)
      state_r <= pss_pkg::PSS_IDLE;
    else if (stalled)
      state_r <= state_r;
    else if (advance)
      state_r <= (lane_we != '0) ? pss_pkg::PSS_WRITE
                                 : pss_pkg::PSS_READ;
    else
      state_r <= pss_pkg::PSS_IDLE;
  end

  // write lanes and data are frozen with the address that goes with them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wlanes_r <= '0;
      wdata_r  <= '0;
    end else if (load_wr) begin
      wlanes_r <= lane_we;
      wdata_r  <= din_r;
    end
  end

  // self-timed array request; a stall holds the beat in state_r until accepted or replaced by a strobe
  assign mem_addr  = cur_addr;
  assign mem_wdata = wdata_r;
  always_comb begin
    case (state_r)
      pss_pkg::PSS_WRITE: mem_lane_we = wlanes_r;
      pss_pkg::PSS_READ:  mem_lane_we = '0;
      pss_pkg::PSS_IDLE:  mem_lane_we = '0;
      default:            mem_lane_we = '0;
    endcase
  end
  assign mem_req_valid = mem_go;

  // read return path through a fifo of DEPTH words
  logic [DATA_W-1:0] f_data;
  logic              f_valid;
  logic              f_in_ready;
  wire               rd_beat = accept
                               && (state_r == pss_pkg::PSS_READ);
  pss_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (mem_rdata),
    .in_valid  (rd_pend_r),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (1'b1)
  );

  // output register gives the fourth-clock first word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_pend_r <= 1'b0;
      dout_r    <= '0;
      dout_v_r  <= 1'b0;
    end else begin
      rd_pend_r <= rd_beat && f_in_ready;
      dout_v_r  <= f_valid && sel_r;
      if (f_valid) dout_r <= f_data;
    end
  end

  // oe and sleep bypass the clock entirely
  assign asleep = sleep_request;
  assign dq_out = dout_r;
  assign dq_oe  = !out_enable_n && dout_v_r && sel_r
                  && !asleep;

  // sizing lives in the parameters; the clock rate limit is the
  // controller's to keep, so nothing here enforces it
  AST_LATCH_ON_STROBE: assert property (@(posedge clk_sys) disable iff (rst)
    strobe |=> base_r == $past(addr_r))
    else $error("address not latched on strobe");
  AST_HOLD_NO_STROBE: assert property (@(posedge clk_sys) disable iff (rst)
    !strobe && !advance |=> $stable(base_r) && $stable(cnt_r))
    else $error("burst state moved without cause");
  AST_STEP: assert property (@(posedge clk_sys) disable iff (rst)
    advance && !stalled |=> cnt_r == $past(cnt_r) + 2'd1)
    else $error("burst counter failed to step");
  AST_WRAP: assert property (@(posedge clk_sys) disable iff (rst)
    !strobe |=> base_r[ADDR_W-1:BW] == $past(base_r[ADDR_W-1:BW]))
    else $error("burst carried into upper address");
  AST_GLOBAL: assert property (@(posedge clk_sys) disable iff (rst)
    !glob_n_r |-> lane_we == {LANES{1'b1}})
    else $error("global write missed a lane");
  AST_GATE: assert property (@(posedge clk_sys) disable iff (rst)
    glob_n_r && gate_n_r |-> lane_we == '0)
    else $error("lane written without gate");
  AST_DESELECT: assert property (@(posedge clk_sys) disable iff (rst)
    strobe && !chip_on |=> !sel_r ##1 !dq_oe)
    else $error("deselect too slow");
  AST_FLOAT: assert property (@(posedge clk_sys) disable iff (rst)
    out_enable_n || sleep_request |-> !dq_oe)
    else $error("driving while disabled");
  AST_ORDER: assert property (@(posedge clk_sys) disable iff (rst)
    !ord_r |-> cur_addr[BW-1:0] == (base_r[BW-1:0] ^ cnt_r))
    else $error("interleaved order wrong");
  AST_WRITE_HELD: assert property (@(posedge clk_sys) disable iff (rst)
    strobe && chip_on && is_write
    |=> mem_lane_we == $past(lane_we) && mem_wdata == $past(din_r))
    else $error("write beat not registered with its address");
  AST_STALL_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    stalled && !strobe |=> $stable(mem_addr) && $stable(state_r))
    else $error("stalled beat changed");
  AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> addr_r == $past(addr) && din_r == $past(dq_in))
    else $error("pin not captured on the edge");
  AST_SLEEP_QUIET: assert property (@(posedge clk_sys) disable iff (rst)
    sleep_request |-> !mem_req_valid && asleep)
    else $error("array request while asleep");
  AST_READ_LAT: assert property (@(posedge clk_sys) disable iff (rst)
    rd_beat && f_in_ready |-> ##3 (dout_v_r || !sel_r))
    else $error("read word late at the output register");
  COV_READ:  cover property (@(posedge clk_sys) rd_beat ##2 dout_v_r);
  COV_WRITE: cover property (@(posedge clk_sys)
    state_r == pss_pkg::PSS_WRITE && mem_req_ready);
  COV_BURST: cover property (@(posedge clk_sys)
    advance ##1 advance ##1 advance);
  COV_STALL: cover property (@(posedge clk_sys) stalled);
  COV_DESEL: cover property (@(posedge clk_sys) strobe && !chip_on);
endmodule : pss_sram_port

// ---- pss_map.svh ----
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH
// array organisation and bus rates
`define PSS_WIDE_DATA_W   36
`define PSS_WIDE_ADDR_W   21
`define PSS_NARROW_DATA_W 18
`define PSS_NARROW_ADDR_W 22
`define PSS_LANE_W        9
`define PSS_BURST_W       2
`define PSS_CLK_MHZ       100
`define PSS_MAX_BUS_MHZ   250
// read pipeline: first word four clocks after the strobe edge; PSS_READ_LAT is unused
`define PSS_READ_LAT      3
`define PSS_FIFO_DEPTH    32
`endif

// ---- pss_pkg.sv ----
package pss_pkg;
  typedef enum logic [2:0] {
    PSS_IDLE  = 3'b001,
    PSS_READ  = 3'b010,
    PSS_WRITE = 3'b100
  } pss_state_e;
endpackage : pss_pkg

// ---- pss_array_model.sv ----
`timescale 1ns/1ps

// array behind the port: answers one beat at a time, can stall
module pss_array_model #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 21,
  parameter int LANES  = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              stall,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [DATA_W-1:0] mem_wdata,
  input  wire logic [LANES-1:0]  mem_lane_we,
  input  wire logic              mem_req_valid,
  output logic                   mem_req_ready,
  output logic [DATA_W-1:0]      mem_rdata
);
  logic [DATA_W-1:0] store [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] rd_r;
  logic              rd_ok_r;

  // a stalled array refuses the beat; the port must hold it
  assign mem_req_ready = !stall;
  // data only in the cycle after the accept, else a flipping pattern
  assign mem_rdata = rd_ok_r ? rd_r : ~rd_r;

  // lane-wise write keeps untouched lanes of the stored word
  always @(posedge clk_sys) begin
    rd_ok_r <= 1'b0;
    if (mem_req_valid && mem_req_ready) begin
      for (int i = 0; i < LANES; i++) begin
        if (mem_lane_we[i]) begin
          store[mem_addr][9*i +: 9] = mem_wdata[9*i +: 9];
        end
      end
      if (mem_lane_we == '0) begin
        rd_r    <= store.exists(mem_addr) ? store[mem_addr] : '0;
        rd_ok_r <= 1'b1;
      end
    end
  end
endmodule : pss_array_model

// ---- test_pss_sram_port.sv ----
`timescale 1ns/1ps
`include "pss_map.svh"

module test_pss_sram_port;
  localparam int DW = `PSS_WIDE_DATA_W;
  localparam int AW = `PSS_WIDE_ADDR_W;
  localparam logic [AW-1:0] BASE = 21'h0000a4;
  logic clk_sys, rst, stall, dq_oe, asleep, mem_req_valid, mem_req_ready;
  logic [AW-1:0] addr, mem_addr;
  logic [DW-1:0] dq_in, dq_out, mem_wdata, mem_rdata;
  logic [3:0]    lane_n, mem_lane_we;
  logic cs_n, ds_hi, ds_lo_n, cpu_n, ctl_n, step_n, gate_n, all_n, oe_n;
  logic sleep_request, linear_order;
  int   error_cnt, cmp_count, cyc;

  pss_sram_port #(.WIDE(1'b1)) uut (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .pipeline_chip_sel_n(cs_n),
    .depth_sel_high(ds_hi), .depth_sel_low_n(ds_lo_n),
    .cpu_addr_strobe_n(cpu_n), .ctrl_addr_strobe_n(ctl_n),
    .burst_step_request_n(step_n), .byte_lane_write_n(lane_n),
    .byte_write_gate_n(gate_n), .all_lanes_write_n(all_n),
    .out_enable_n(oe_n), .sleep_request(sleep_request),
    .linear_order(linear_order), .asleep(asleep), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_lane_we(mem_lane_we),
    .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
    .mem_rdata(mem_rdata));

  pss_array_model u_arr (
    .clk_sys(clk_sys), .stall(stall), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_lane_we(mem_lane_we),
    .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
    .mem_rdata(mem_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  // one controller-strobed write; lanes chosen by gate, lane mask, global
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d,
                    input logic g_n, input logic b_n, input logic [3:0] l_n);
    int k;
    @(posedge clk_sys);
    ctl_n <= 1'b0; addr <= a; dq_in <= d;
    all_n <= g_n; gate_n <= b_n; lane_n <= l_n;
    @(posedge clk_sys);
    ctl_n <= 1'b1; all_n <= 1'b1; gate_n <= 1'b1; lane_n <= 4'hf;
    for (k = 0; k < 30; k++) begin
      @(posedge clk_sys);
      stall <= (k < 3) ? stall : 1'b0; // slow array releases later
      if (mem_req_valid && mem_req_ready && mem_lane_we != 4'h0) break;
    end
    @(posedge clk_sys);
  endtask : wr

  // processor-strobed four-beat burst; gathers settled data words
  task automatic rd_burst(input logic lin);
    logic [DW-1:0] q[$];
    int k;
    @(posedge clk_sys);
    cpu_n <= 1'b0; addr <= BASE | 21'h1; linear_order <= lin;
    for (k = 0; k < 12 && q.size() < 4; k++) begin
      @(posedge clk_sys);
      cpu_n <= 1'b1;
      step_n <= (k < 3) ? 1'b0 : 1'b1;
      #1;
      if (dq_oe === 1'b1) q.push_back(dq_out);
    end
    step_n <= 1'b1;
    chk(DW'(q.size()), DW'(4));
    for (k = 0; k < q.size(); k++) begin
      chk(q[k], u_arr.store[BASE | AW'(lin ? ((1 + k) & 3) : (1 ^ k))]);
    end
  endtask : rd_burst

  // output drive follows the enable pin without a clock, then deselect
  task automatic oe_deselect;
    int k;
    @(posedge clk_sys);
    cpu_n <= 1'b0; addr <= BASE;
    @(posedge clk_sys);
    cpu_n <= 1'b1;
    for (k = 0; k < 8 && dq_oe !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(DW'(dq_oe), DW'(1));
    #1 oe_n = 1'b1;
    #1 chk(DW'(dq_oe), DW'(0));
    oe_n = 1'b0;
    #1 chk(DW'(dq_oe), DW'(1));
    @(posedge clk_sys);
    ctl_n <= 1'b0; cs_n <= 1'b1;
    @(posedge clk_sys);
    ctl_n <= 1'b1;
    @(posedge clk_sys);
    #1 chk(DW'(dq_oe), DW'(0));
    cs_n <= 1'b0;
  endtask : oe_deselect

  initial begin
    error_cnt = 0; cmp_count = 0; cyc = 0; rst = 1'b1; stall = 1'b0;
    addr = '0; dq_in = '0; cs_n = 1'b0; ds_hi = 1'b1; ds_lo_n = 1'b0;
    cpu_n = 1'b1; ctl_n = 1'b1; step_n = 1'b1; lane_n = 4'hf;
    gate_n = 1'b1; all_n = 1'b1; oe_n = 1'b0; sleep_request = 1'b0;
    linear_order = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1 chk(DW'({dq_oe, mem_req_valid}), DW'(0));
    @(posedge clk_sys);
    rst <= 1'b0;
    // global write overrides disabled lane enables
    for (int i = 0; i < 4; i++) begin
      wr(BASE | AW'(i), 36'h1_2345_6780 + DW'(i), 1'b0, 1'b1, 4'hf);
      chk(u_arr.store[BASE | AW'(i)], 36'h1_2345_6780 + DW'(i));
    end
    // lane 0 only, through the gate, with a stalling array
    stall <= 1'b1;
    wr(BASE, 36'hf_ffff_ffaa, 1'b1, 1'b0, 4'he);
    chk(u_arr.store[BASE], 36'h1_2345_67aa);
    // gate inactive: lane enables alone must write nothing
    wr(BASE, 36'h0_0000_0000, 1'b1, 1'b1, 4'h0);
    chk(u_arr.store[BASE], 36'h1_2345_67aa);
    rd_burst(1'b1);
    rd_burst(1'b0);
    oe_deselect();
    sleep_request <= 1'b1;
    #1 chk(DW'(asleep), DW'(1));
    sleep_request <= 1'b0;
    test_done();
  end
endmodule : test_pss_sram_port
